// [bench/pin_model.sv]
// Far-side model: event pin, trigger pin and timer 1 overflow
`timescale 1ns/100ps
module pin_model (
  input  wire logic clk,
  output logic      event_pin,
  output logic      trig_pin,
  output logic      t1_ovf
);
  // Pins idle high, overflow idle low
  initial begin
    event_pin = 1'b1;
    trig_pin  = 1'b1;
    t1_ovf    = 1'b0;
  end
  // Falling edge, each level held well past two machine cycles
  task automatic fall(input bit trig);
    @(posedge clk);
    if (trig) trig_pin <= 1'b0;
    else event_pin <= 1'b0;
    repeat (30) @(posedge clk);
    trig_pin  <= 1'b1;
    event_pin <= 1'b1;
    repeat (30) @(posedge clk);
  endtask
  // One-cycle overflow pulse of the other timer
  task automatic pulse_t1();
    @(posedge clk);
    t1_ovf <= 1'b1;
    @(posedge clk);
    t1_ovf <= 1'b0;
  endtask
endmodule // pin_model

// [bench/timer2_capture_reload_control_tb.sv]
// Self-checking bench for timer 2 over its register bus and pins
`timescale 1ns/100ps
module timer2_capture_reload_control_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  be = 4'hF;
  logic        ce = 1'b1;
  logic [31:0] rdat;
  logic        wreq;
  logic        ev;
  logic        trg;
  logic        t1;
  logic        sclk;
  logic        irq;
  logic [31:0] got;
  logic [7:0]  offs [8] = '{8'hC8, 8'hCC, 8'hD0, 8'hD4, 8'hD8, 8'hDC, 8'hE0, 8'h00};
  int          miscompares = 0;
  int          n_checks = 0;
  int          pulses;
  // Clock, 25 ns period
  always #12.5 clk = ~clk;
  timer2_capture_reload_control dut (.CORE_CLK(clk), .RST_N(rst_n), .CE(ce), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .EVENT_PIN(ev), .EXTERNAL_TRIGGER_PIN(trg), .TIMER1_OVERFLOW(t1),
    .SERIAL_CLOCK(sclk), .IRQ(irq));
  pin_model pins (.clk(clk), .event_pin(ev), .trig_pin(trg), .t1_ovf(t1));
  // ==========================================================
  // Report and checks
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // ==========================================================
  // Bus access: hold until ready is sampled low, bounded
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    adr  <= a;
    wdat <= {24'h0, d};
    wr   <= w;
    rd   <= !w;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    if (n == 20) begin
      miscompares++;
      summarize();
    end
    got = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(got, {24'h0, e});
  endtask
  // Count serial clock pulses over four machine cycles, from a pulse when one is due
  task automatic count_pulses(input bit sync);
    int n;
    pulses = 0;
    if (sync) begin
      for (n = 0; n < 24 && sclk !== 1'b1; n++) @(posedge clk);
      if (n == 24) begin
        miscompares++;
        summarize();
      end
    end else begin
      @(posedge clk);
    end
    repeat (48) begin
      @(posedge clk);
      pulses += sclk;
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (offs[i]) rchk(offs[i], 8'h00);
    wr8(8'h00, 8'hFF);
    rchk(8'h00, 8'h00);
    be <= 4'hE;
    wr8(8'hC8, 8'h20);
    be <= 4'hF;
    rchk(8'hC8, 8'h00);
    wr8(8'hC8, 8'h20);
    rchk(8'hC8, 8'h20);
    // Rollover in timer mode reloads and flags
    wr8(8'hE0, 8'h03);
    wr8(8'hD4, 8'h34);
    wr8(8'hD8, 8'h12);
    wr8(8'hCC, 8'hFE);
    wr8(8'hD0, 8'hFF);
    wr8(8'hC8, 8'h04);
    for (int n = 0; n < 100 && irq !== 1'b1; n++) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rchk(8'hC8, 8'h84);
    rchk(8'hDC, 8'h01);
    rchk(8'hD0, 8'h12);
    wr8(8'hDC, 8'h01);
    wr8(8'hC8, 8'h00);
    rchk(8'hC8, 8'h00);
    chk({31'h0, irq}, 32'h0);
    // Stopped counter holds its value
    bus(1'b0, 8'hCC, 8'h00);
    pulses = got;
    repeat (40) @(posedge clk);
    rchk(8'hCC, pulses[7:0]);
    // Capture on trigger edge, then one event step
    wr8(8'hCC, 8'h55);
    wr8(8'hD0, 8'hAA);
    wr8(8'hC8, 8'h0F);
    pins.fall(1'b1);
    rchk(8'hD4, 8'h55);
    rchk(8'hD8, 8'hAA);
    rchk(8'hC8, 8'h4F);
    rchk(8'hDC, 8'h02);
    chk({31'h0, irq}, 32'h1);
    wr8(8'hE0, 8'h01);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr8(8'hE0, 8'h03);
    pins.fall(1'b0);
    rchk(8'hCC, 8'h56);
    // Clock enable low freezes the event counter
    ce <= 1'b0;
    pins.fall(1'b0);
    ce <= 1'b1;
    rchk(8'hCC, 8'h56);
    // Reload on trigger edge, then trigger disabled
    wr8(8'hDC, 8'h03);
    wr8(8'hC8, 8'h0E);
    pins.fall(1'b1);
    rchk(8'hCC, 8'h55);
    rchk(8'hC8, 8'h4E);
    wr8(8'hC8, 8'h06);
    pins.fall(1'b1);
    rchk(8'hC8, 8'h06);
    rchk(8'hCC, 8'h55);
    // Baud mode: one pulse per rollover, no flags
    wr8(8'hD4, 8'hFF);
    wr8(8'hD8, 8'hFF);
    wr8(8'hCC, 8'hFF);
    wr8(8'hD0, 8'hFF);
    wr8(8'hC8, 8'h1D);
    count_pulses(1'b1);
    chk(pulses, 32'h4);
    pins.fall(1'b1);
    rchk(8'hC8, 8'h1D);
    wr8(8'hC8, 8'h10);
    count_pulses(1'b0);
    chk(pulses, 32'h0);
    // Timer 1 overflow reaches the serial port
    wr8(8'hC8, 8'h00);
    pins.pulse_t1();
    @(posedge clk);
    chk({31'h0, sclk}, 32'h1);
    summarize();
  end
endmodule // timer2_capture_reload_control_tb

// [bench/timer2_monitor.sv]
// Checker: bus and output properties at the timer 2 ports
`timescale 1ns/100ps
module timer2_monitor #(
  parameter int DIV = 12
) (
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  input wire logic        CE,
  input wire logic [7:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        EVENT_PIN,
  input wire logic        EXTERNAL_TRIGGER_PIN,
  input wire logic        TIMER1_OVERFLOW,
  input wire logic        SERIAL_CLOCK,
  input wire logic        IRQ
);
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [1:0] mask_q;
  logic [1:0] mask_d;
  logic       wr_ok;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // ==========================================================
  // Shadow of software-owned control bits and interrupt mask
  assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] && CE;
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    if (wr_ok && AVS_ADDRESS == timer2_pkg::CTRL_OFS) ctrl_d = AVS_WRITEDATA[7:0];
    if (wr_ok && AVS_ADDRESS == timer2_pkg::IRQ_MASK_OFS) mask_d = AVS_WRITEDATA[1:0];
  end
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= 8'h00;
      mask_q <= 2'h0;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
    end
  end
  // ==========================================================
  // Properties
  AST_WAIT_ANSWER: assert property ($rose(AVS_READ) || $rose(AVS_WRITE) |=> !AVS_WAITREQUEST)
    else $error("no answer one cycle after request");
  AST_WAIT_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("ready held longer than one cycle");
  AST_IDLE_WAIT: assert property (!AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
    else $error("ready without request");
  AST_UPPER_ZERO: assert property (AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_CTRL_SOFT: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == timer2_pkg::CTRL_OFS
    |-> AVS_READDATA[5:0] == ctrl_q[5:0])
    else $error("control readback differs from written bits");
  AST_T1_ROUTE: assert property (!ctrl_q[4] && TIMER1_OVERFLOW |=> SERIAL_CLOCK)
    else $error("timer 1 overflow not passed on");
  AST_T1_QUIET: assert property (!ctrl_q[4] && !TIMER1_OVERFLOW |=> !SERIAL_CLOCK)
    else $error("serial clock without timer 1 overflow");
  AST_BAUD_PULSE: assert property (ctrl_q[4] && SERIAL_CLOCK |=> !SERIAL_CLOCK)
    else $error("baud pulse longer than one cycle");
  AST_OFF_SILENT: assert property ((ctrl_q[4] && !ctrl_q[2]) [*4] |-> !SERIAL_CLOCK)
    else $error("baud pulse while stopped");
  AST_MASK_QUIET: assert property (mask_q == 2'h0 |=> !IRQ)
    else $error("interrupt with all sources masked");
  // Main scenarios reached
  cover property (ctrl_q[4] && SERIAL_CLOCK);
  cover property ($rose(IRQ));
  cover property (!ctrl_q[4] && TIMER1_OVERFLOW);
endmodule // timer2_monitor
bind timer2_capture_reload_control timer2_monitor #(.DIV(DIV)) mon (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CE(CE),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .EVENT_PIN(EVENT_PIN), .EXTERNAL_TRIGGER_PIN(EXTERNAL_TRIGGER_PIN), .TIMER1_OVERFLOW(TIMER1_OVERFLOW),
  .SERIAL_CLOCK(SERIAL_CLOCK), .IRQ(IRQ));

// [rtl/fall_edge_sampler.sv]
// Falling-edge detector that samples a pin once per machine cycle
`timescale 1ns/100ps
module fall_edge_sampler (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic sample,
  input  wire logic pin,
  output logic      fall
);

  logic last_q;
  logic last_d;
  logic fall_d;

  // High then low on two successive samples is one edge
  always_comb begin
    last_d = sample ? pin : last_q;
    fall_d = sample & last_q & ~pin;
  end

  // Idle level of the pin is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 1'b1;
      fall   <= 1'b0;
    end else if (ce) begin
      last_q <= last_d;
      fall   <= fall_d;
    end
  end

endmodule // fall_edge_sampler

// [rtl/machine_cycle_divider.sv]
// Divider that marks one core clock in every machine cycle
`timescale 1ns/100ps
module machine_cycle_divider #(
  parameter int DIV = timer2_pkg::MACHINE_CYCLE_CLOCKS
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  output logic      tick
);

  localparam int CW = $clog2(DIV);

  // ==========================================================
  // Elaboration check
  if (DIV < 2) begin : g_bad_div
    $error("DIV must be at least 2");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          tick_d;

  // Count 0 to DIV-1 and flag the wrap
  always_comb begin
    tick_d = (cnt_q == CW'(DIV - 1));
    cnt_d  = tick_d ? '0 : cnt_q + 1'b1;
  end

  // Register the count and the tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      tick  <= tick_d;
    end
  end

endmodule // machine_cycle_divider

// [rtl/timer2_capture_reload_control.sv]
// Timer 2: 16-bit capture, auto-reload and baud generator with Avalon-MM registers
//
// Notes on behaviour
// - Overflow sets control bit 7; only a software write clears it.
// - No overflow flag while the serial clock select bit is set.
// - Trigger-pin capture or reload sets control bit 6, external flag.
// - External flag raises the interrupt when enabled; stays until software clears.
// - Bit 5 is a spare read/write flag with no timer effect.
// - Bit 4 routes this timer's overflows, else timer 1's, to the serial port.
// - Bit 3 lets trigger falling edges act unless clocking the serial port.
// - Bit 2 runs the timer; clear means off whatever the other bits.
// - Bit 1 clear counts machine cycles; set counts event pin falling edges.
// - Bit 0 set with trigger enabled: trigger falling edges capture the count.
// - Bit 0 clear: reload on overflow and on enabled trigger edges.
// - Serial clock select forces reload on overflow, ignoring bit 0.
// - Mode from select, capture and run bits: reload, capture, baud, off.
// - Eight-bit control register at C8H with the bit order above.
// - Capture copies the count bytes into the capture/reload bytes.
// - Reload loads the counter from the software-preset capture/reload pair.
// - Counter is 16 bits, as timer or as event counter.
`timescale 1ns/100ps
module timer2_capture_reload_control #(
  parameter int DIV = timer2_pkg::MACHINE_CYCLE_CLOCKS
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        EVENT_PIN,
  input  wire logic        EXTERNAL_TRIGGER_PIN,
  input  wire logic        TIMER1_OVERFLOW,
  output logic             SERIAL_CLOCK,
  output logic             IRQ
);

  localparam int CW = timer2_pkg::COUNT_W;

  // ==========================================================
  // Elaboration check
  if (DIV < 2) begin : g_bad_div
    $error("DIV must be at least 2");
  end

  // Byte registers split a 16-bit count
  if (CW != 16) begin : g_bad_width
    $error("COUNT_W must be 16 for the byte registers");
  end

  // ==========================================================
  // Reset release through two flip-flops
  logic rst_meta_q;
  logic rst_q;

  // Assert at once, release two edges later
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_q <= 1'b0;
      rst_q      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q      <= rst_meta_q;
    end
  end

  // ==========================================================
  // Machine cycle tick and pin edges
  logic mc_tick;
  logic evt_fall;
  logic trg_fall;

  machine_cycle_divider #(
    .DIV (DIV)
  ) u_div (
    .clk   (CORE_CLK),
    .rst_n (rst_q),
    .ce    (CE),
    .tick  (mc_tick)
  );

  // Event pin edges for counter mode
  fall_edge_sampler u_evt (
    .clk    (CORE_CLK),
    .rst_n  (rst_q),
    .ce     (CE),
    .sample (mc_tick),
    .pin    (EVENT_PIN),
    .fall   (evt_fall)
  );

  // Trigger pin edges for capture and reload
  fall_edge_sampler u_trg (
    .clk    (CORE_CLK),
    .rst_n  (rst_q),
    .ce     (CE),
    .sample (mc_tick),
    .pin    (EXTERNAL_TRIGGER_PIN),
    .fall   (trg_fall)
  );

  // ==========================================================
  // State
  logic [7:0]          ctrl_q;
  logic [7:0]          ctrl_d;
  logic [CW-1:0]       count_q;
  logic [CW-1:0]       count_d;
  logic [CW-1:0]       reload_q;
  logic [CW-1:0]       reload_d;
  logic [1:0]          stat_q;
  logic [1:0]          stat_d;
  logic [1:0]          mask_q;
  logic [1:0]          mask_d;
  logic                wait_q;
  logic                wait_d;
  logic [31:0]         rdata_q;
  logic [31:0]         rdata_d;
  logic                ser_clk_q;
  logic                ser_clk_d;
  logic                irq_q;
  logic                irq_d;

  // ==========================================================
  // Mode decode
  timer2_pkg::mode_type mode;
  logic ser_sel;
  logic trig_en;
  logic run;
  logic src_sel;
  logic cap_sel;
  logic step;
  logic ovf;
  logic trig;
  logic reload_on_ovf;
  logic capture_mode;

  assign ser_sel = ctrl_q[timer2_pkg::SER_SEL_BIT];
  assign trig_en = ctrl_q[timer2_pkg::TRIG_EN_BIT];
  assign run     = ctrl_q[timer2_pkg::RUN_BIT];
  assign src_sel = ctrl_q[timer2_pkg::SRC_SEL_BIT];
  assign cap_sel = ctrl_q[timer2_pkg::CAP_SEL_BIT];

  // Run off wins, then serial select, then capture select
  always_comb begin
    if (!run) begin
      mode = timer2_pkg::MODE_OFF;
    end else if (ser_sel) begin
      mode = timer2_pkg::MODE_BAUD;
    end else if (cap_sel) begin
      mode = timer2_pkg::MODE_CAPT;
    end else begin
      mode = timer2_pkg::MODE_RELOAD;
    end
  end

  // What each mode does on overflow and on a trigger edge
  always_comb begin
    reload_on_ovf = 1'b0;
    capture_mode  = 1'b0;
    unique case (mode)
      timer2_pkg::MODE_OFF: begin
      end
      timer2_pkg::MODE_RELOAD: begin
        reload_on_ovf = 1'b1;
      end
      timer2_pkg::MODE_CAPT: begin
        capture_mode = 1'b1;
      end
      timer2_pkg::MODE_BAUD: begin
        reload_on_ovf = 1'b1;
      end
    endcase
  end

  // Count source, rollover and gated trigger
  always_comb begin
    step = (mode != timer2_pkg::MODE_OFF) & (src_sel ? evt_fall : mc_tick);
    ovf  = step & (count_q == {CW{1'b1}});
    trig = (mode != timer2_pkg::MODE_OFF) & ~ser_sel & trig_en & trg_fall;
  end

  // ==========================================================
  // Bus decode
  logic       wr_fire;
  logic       rd_take;
  logic       be0;
  logic [7:0] wbyte;

  assign be0     = AVS_BYTEENABLE[0];
  assign wbyte   = AVS_WRITEDATA[7:0];
  assign wr_fire = ~wait_q & AVS_WRITE & be0;
  assign rd_take = wait_q & AVS_READ;

  // One wait state per request, then a single ready cycle
  always_comb begin
    wait_d = ~((AVS_READ | AVS_WRITE) & wait_q);
  end

  // Read mux, sampled in the request cycle
  always_comb begin
    rdata_d = rdata_q;
    if (rd_take) begin
      rdata_d = 32'h0000_0000;
      unique case (AVS_ADDRESS)
        timer2_pkg::CTRL_OFS:      rdata_d[7:0] = ctrl_q;
        timer2_pkg::COUNT_LO_OFS:  rdata_d[7:0] = count_q[7:0];
        timer2_pkg::COUNT_HI_OFS:  rdata_d[7:0] = count_q[15:8];
        timer2_pkg::RELOAD_LO_OFS: rdata_d[7:0] = reload_q[7:0];
        timer2_pkg::RELOAD_HI_OFS: rdata_d[7:0] = reload_q[15:8];
        timer2_pkg::IRQ_STAT_OFS:  rdata_d[1:0] = stat_q;
        timer2_pkg::IRQ_MASK_OFS:  rdata_d[1:0] = mask_q;
        default:                   rdata_d      = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Bus answer registers
  always_ff @(posedge CORE_CLK or negedge rst_q) begin
    if (!rst_q) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (CE) begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Timer core: software writes first, hardware events win
  always_comb begin
    ctrl_d   = ctrl_q;
    count_d  = count_q;
    reload_d = reload_q;
    if (wr_fire) begin
      unique case (AVS_ADDRESS)
        timer2_pkg::CTRL_OFS:      ctrl_d          = wbyte;
        timer2_pkg::COUNT_LO_OFS:  count_d[7:0]    = wbyte;
        timer2_pkg::COUNT_HI_OFS:  count_d[15:8]   = wbyte;
        timer2_pkg::RELOAD_LO_OFS: reload_d[7:0]   = wbyte;
        timer2_pkg::RELOAD_HI_OFS: reload_d[15:8]  = wbyte;
        default: begin
        end
      endcase
    end
    // Increment, reloading at rollover where the mode asks
    if (step) begin
      count_d = (ovf & reload_on_ovf) ? reload_q : count_q + 1'b1;
    end
    // Trigger edge: capture or reload
    if (trig & capture_mode) begin
      reload_d = count_q;
    end
    if (trig & ~capture_mode) begin
      count_d = reload_q;
    end
    // Flags set after the software write, so a set wins
    if (ovf & ~ser_sel) begin
      ctrl_d[timer2_pkg::OVF_FLAG_BIT] = 1'b1;
    end
    if (trig) begin
      ctrl_d[timer2_pkg::EXT_FLAG_BIT] = 1'b1;
    end
  end

  // ==========================================================
  // Timer core registers
  always_ff @(posedge CORE_CLK or negedge rst_q) begin
    if (!rst_q) begin
      ctrl_q   <= timer2_pkg::CTRL_RESET;
      count_q  <= timer2_pkg::COUNT_RESET;
      reload_q <= timer2_pkg::RELOAD_RESET;
    end else if (CE) begin
      ctrl_q   <= ctrl_d;
      count_q  <= count_d;
      reload_q <= reload_d;
    end
  end

  // ==========================================================
  // Serial clock source: own rollover pulses or timer 1
  always_comb begin
    ser_clk_d = ser_sel ? ovf : TIMER1_OVERFLOW;
  end

  // Serial clock pulse register
  always_ff @(posedge CORE_CLK or negedge rst_q) begin
    if (!rst_q) begin
      ser_clk_q <= 1'b0;
    end else if (CE) begin
      ser_clk_q <= ser_clk_d;
    end
  end

  // ==========================================================
  // Interrupt status, write one to clear, set wins
  always_comb begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (wr_fire && AVS_ADDRESS == timer2_pkg::IRQ_STAT_OFS) begin
      stat_d = stat_q & ~wbyte[1:0];
    end
    if (wr_fire && AVS_ADDRESS == timer2_pkg::IRQ_MASK_OFS) begin
      mask_d = wbyte[1:0];
    end
    // Hardware sets after the clear, so a set wins
    if (ovf & ~ser_sel) begin
      stat_d[timer2_pkg::IRQ_OVF_BIT] = 1'b1;
    end
    if (trig) begin
      stat_d[timer2_pkg::IRQ_EXT_BIT] = 1'b1;
    end
    irq_d = |(stat_d & mask_d);
  end

  // ==========================================================
  // Interrupt registers
  always_ff @(posedge CORE_CLK or negedge rst_q) begin
    if (!rst_q) begin
      stat_q <= timer2_pkg::IRQ_RESET;
      mask_q <= timer2_pkg::IRQ_RESET;
      irq_q  <= 1'b0;
    end else if (CE) begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q  <= irq_d;
    end
  end

  // ==========================================================
  // Outputs straight from flip-flops
  assign AVS_READDATA    = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign SERIAL_CLOCK    = ser_clk_q;
  assign IRQ             = irq_q;

endmodule // timer2_capture_reload_control

// [rtl/timer2_pkg.sv]
// Package: register map, field positions, reset values and timing counts of timer 2
package timer2_pkg;

  // ==========================================================
  // Register byte addresses on the Avalon-MM slave
  localparam logic [7:0] CTRL_OFS     = 8'hC8;
  localparam logic [7:0] COUNT_LO_OFS = 8'hCC;
  localparam logic [7:0] COUNT_HI_OFS = 8'hD0;
  localparam logic [7:0] RELOAD_LO_OFS = 8'hD4;
  localparam logic [7:0] RELOAD_HI_OFS = 8'hD8;
  localparam logic [7:0] IRQ_STAT_OFS = 8'hDC;
  localparam logic [7:0] IRQ_MASK_OFS = 8'hE0;

  // ==========================================================
  // Control register fields
  localparam int OVF_FLAG_BIT  = 7;
  localparam int EXT_FLAG_BIT  = 6;
  localparam int SPARE_BIT     = 5;
  localparam int SER_SEL_BIT   = 4;
  localparam int TRIG_EN_BIT   = 3;
  localparam int RUN_BIT       = 2;
  localparam int SRC_SEL_BIT   = 1;
  localparam int CAP_SEL_BIT   = 0;

  // Interrupt status and mask fields
  localparam int IRQ_OVF_BIT   = 0;
  localparam int IRQ_EXT_BIT   = 1;
  localparam int IRQ_W         = 2;

  // ==========================================================
  // Widths and reset values
  localparam int COUNT_W = 16;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [1:0]  IRQ_RESET    = 2'h0;

  // Core clocks in one machine cycle
  localparam int MACHINE_CYCLE_CLOCKS = 12;

  // ==========================================================
  // Operating modes, one-hot
  typedef enum logic [3:0] {
    MODE_OFF    = 4'b0001,
    MODE_RELOAD = 4'b0010,
    MODE_CAPT   = 4'b0100,
    MODE_BAUD   = 4'b1000
  } mode_type;

endpackage
